// [bus_master_model.sv]
// bus-matrix master model facing the allocator's system port
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input  wire logic        core_clk,   // master clock
    input  wire logic        bus_ready,  // access done
    input  wire logic        bus_error,  // unmapped address
    input  wire logic [2:0]  bus_target, // decoded target
    input  wire logic [2:0]  bus_block,  // fast sram block
    input  wire logic [13:0] bus_offset, // offset in block
    input  wire logic [3:0]  periph_sel, // peripheral slot
    output logic             bus_req,    // access valid
    output logic      [31:0] bus_addr    // access address
);
    // ----------------------------------------
    // access sequencing
    // ----------------------------------------
    // idle with a scrambled address at time zero
    initial begin
        bus_req  = 1'b0;
        bus_addr = 32'h5a5a_a5a5;
    end
    // request held through one edge past the cycle ready is seen, four cycles at most; released address inverted
    task automatic access(input logic [31:0] a, output logic [2:0] tgt,
                          output logic [2:0] blk, output logic [13:0] off,
                          output logic [3:0] sel, output logic err,
                          output int n);
        n = 0;
        @(posedge core_clk);
        #1 bus_req = 1'b1;
        bus_addr = a;
        do begin
            @(posedge core_clk);
            #1 n++;
        end while (bus_ready !== 1'b1 && n < 4);
        tgt = bus_target;
        blk = bus_block;
        off = bus_offset;
        sel = periph_sel;
        err = bus_error;
        @(posedge core_clk);
        #1 bus_req = 1'b0;
        bus_addr = ~a;
    endtask : access
endmodule : bus_master_model
`default_nettype wire

// [slot_to_block.sv]
// maps a system-bus slot index to a physical block number
`timescale 1ns/1ps
`default_nettype none
`include "sram_alloc_cfg.svh"
module slot_to_block
    import sram_alloc_pkg::*;
(
    input  wire logic [1:0] instr_size,  // instr coupled area size
    input  wire logic [1:0] data_size,   // data coupled area size
    input  wire logic [2:0] slot,        // system-bus slot index
    output logic            valid,       // slot exists in this layout
    output logic      [2:0] block        // physical block number
);
    logic [4:0] claimed;
    logic [2:0] cnt;
    // mark blocks taken by coupled areas
    always_comb begin
        claimed = 5'h00;
        if (instr_size != 2'h0) claimed[`INSTR_FIRST] = 1'b1;
        if (instr_size == 2'h2) claimed[`INSTR_SECOND] = 1'b1;
        if (data_size != 2'h0)  claimed[`DATA_FIRST] = 1'b1;
        if (data_size == 2'h2)  claimed[`DATA_SECOND] = 1'b1;
    end
    // walk blocks downward, pick slot-th free one
    always_comb begin
        valid = 1'b0;
        block = `TOP_BLOCK;
        cnt   = 3'h0;
        for (int i = 4; i >= 0; i--) begin
            if (!claimed[i]) begin
                if (cnt == slot && !valid) begin
                    valid = 1'b1;
                    block = 3'(i);
                end
                cnt = cnt + 3'h1;
            end
        end
    end
endmodule : slot_to_block
`default_nettype wire

// [sram_alloc_cfg.svh]
// address map and allocation constants for the fast sram allocator
`ifndef SRAM_ALLOC_CFG_SVH
`define SRAM_ALLOC_CFG_SVH
`define BLOCK_BYTES      32'h0000_4000
`define BLOCK_AW         14
`define INSTR_BASE       32'h0010_0000
`define DATA_BASE        32'h0020_0000
`define SYS_BASE         32'h0030_0000
`define SRAM16_BASE      32'h0050_0000
`define PERIPH_LO        32'hfffa_0000
`define PERIPH_HI        32'hfffc_ffff
`define AREA_SPAN        32'h0001_4000
`define TCM_SPAN         32'h0000_8000
`define NUM_BLOCKS       3'h5
`define TOP_BLOCK        3'h4
`define INSTR_FIRST      3'h1
`define INSTR_SECOND     3'h0
`define DATA_FIRST       3'h3
`define DATA_SECOND      3'h2
`define SIZE_RESET       2'h0
`define NUM_PERIPH       4'hc
`endif

// [sram_alloc_pkg.sv]
// types shared by the fast sram allocator
package sram_alloc_pkg;
    typedef enum logic [1:0] {
        SIZE_0K  = 2'b00,
        SIZE_16K = 2'b01,
        SIZE_32K = 2'b10
    } tcm_size_type;
    typedef enum logic [2:0] {
        TGT_NONE   = 3'b000,
        TGT_FAST   = 3'b001,
        TGT_SRAM16 = 3'b010,
        TGT_ROM    = 3'b011,
        TGT_EXT0   = 3'b100,
        TGT_PERIPH = 3'b101
    } target_type;
endpackage : sram_alloc_pkg

// [sram_bank_alloc.sv]
// address decode and bank allocation for the 80 kbyte fast sram
`timescale 1ns/1ps
`default_nettype none
`include "sram_alloc_cfg.svh"
module sram_bank_alloc
    import sram_alloc_pkg::*;
(
    input  wire logic        core_clk,       // master clock
    input  wire logic        rst_n,          // async reset, active low
    input  wire logic [1:0]  instr_size_cfg, // instr area size request
    input  wire logic [1:0]  data_size_cfg,  // data area size request
    input  wire logic        remap,          // remap flag
    input  wire logic        boot_source_select, // boot strap pin
    input  wire logic        bus_req,        // bus-matrix access valid
    input  wire logic [31:0] bus_addr,       // bus-matrix address
    input  wire logic        instr_port_req,  // instr coupled port access
    input  wire logic [14:0] instr_port_addr, // instr coupled offset
    input  wire logic        data_port_req,   // data coupled port access
    input  wire logic [14:0] data_port_addr,  // data coupled offset
    output logic             bus_ready,      // bus access done
    output logic             bus_error,      // unmapped bus address
    output logic       [2:0] bus_target,     // target_type code
    output logic       [2:0] bus_block,      // fast sram block
    output logic [13:0]      bus_offset,     // offset inside block
    output logic       [3:0] periph_sel,     // peripheral slot number
    output logic             instr_port_ready, // instr port done
    output logic       [2:0] instr_port_block, // instr port block
    output logic             data_port_ready,  // data port done
    output logic       [2:0] data_port_block,  // data port block
    output logic       [1:0] instr_size,     // active instr size
    output logic       [1:0] data_size,      // active data size
    output logic             boot_sel        // latched boot strap
);
    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  sync;
        logic [1:0]  fill;
        logic        strap_done;
        logic        boot_sel;
        logic [1:0]  instr_size;
        logic [1:0]  data_size;
        logic        bus_ready;
        logic        bus_error;
        logic [2:0]  bus_target;
        logic [2:0]  bus_block;
        logic [13:0] bus_offset;
        logic [3:0]  periph_sel;
        logic        instr_port_ready;
        logic [2:0]  instr_port_block;
        logic        data_port_ready;
        logic [2:0]  data_port_block;
    } state_type;

    state_type cur;
    state_type next_cur;

    logic [2:0]  slot;
    logic        slot_ok;
    logic [2:0]  slot_blk;
    logic [31:0] sys_off;
    logic [31:0] z_off;
    logic        in_sys;
    logic [31:0] bus_eff;

    // zero window aliases the system-bus area after remap
    assign z_off   = bus_addr;
    assign in_sys  = (bus_addr >= `SYS_BASE) &&
                     (bus_addr < `SYS_BASE + `AREA_SPAN);
    assign bus_eff = (remap && bus_addr < `AREA_SPAN) ? z_off : 
                     bus_addr - `SYS_BASE;
    assign sys_off = bus_eff;
    assign slot    = sys_off[16:14];

    // system-bus slot lookup on the sizes in force
    slot_to_block u_slot (
        .instr_size (cur.instr_size),
        .data_size  (cur.data_size),
        .slot       (slot),
        .valid      (slot_ok),
        .block      (slot_blk)
    );

    //------------------------------------------------------------
    // next state
    //------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.sync = {cur.sync[1:0], boot_source_select};
        // strap caught once the pin has filled all three stages
        if (cur.fill != 2'h3)
            next_cur.fill = cur.fill + 2'h1;
        if (!cur.strap_done && cur.fill == 2'h3 &&
            cur.sync[2] == cur.sync[1]) begin
            next_cur.boot_sel   = cur.sync[2];
            next_cur.strap_done = 1'b1;
        end
        // sizes move only between accesses
        if (!bus_req && !instr_port_req && !data_port_req) begin
            if (instr_size_cfg <= 2'h2)
                next_cur.instr_size = instr_size_cfg;
            if (data_size_cfg <= 2'h2)
                next_cur.data_size = data_size_cfg;
        end
        next_cur.bus_ready  = bus_req;
        next_cur.bus_error  = 1'b0;
        next_cur.bus_target = TGT_NONE;
        next_cur.bus_block  = 3'h0;
        next_cur.bus_offset = bus_addr[13:0];
        next_cur.periph_sel = 4'h0;
        if (bus_req) begin
            if (bus_addr < `AREA_SPAN && remap) begin
                next_cur.bus_target = slot_ok ? TGT_FAST : TGT_NONE;
                next_cur.bus_block  = slot_blk;
                next_cur.bus_error  = !slot_ok;
            end else if (bus_addr < `BLOCK_BYTES * 32'h8) begin
                next_cur.bus_target = cur.boot_sel ? TGT_ROM : TGT_EXT0;
            end else if (in_sys) begin
                next_cur.bus_target = slot_ok ? TGT_FAST : TGT_NONE;
                next_cur.bus_block  = slot_blk;
                next_cur.bus_error  = !slot_ok;
            end else if (bus_addr >= `INSTR_BASE &&
                         bus_addr < `INSTR_BASE + `TCM_SPAN &&
                         (bus_addr[14] ? cur.instr_size == 2'h2
                                       : cur.instr_size != 2'h0)) begin
                next_cur.bus_target = TGT_FAST;
                next_cur.bus_block  = bus_addr[14] ? `INSTR_SECOND
                                                   : `INSTR_FIRST;
            end else if (bus_addr >= `DATA_BASE &&
                         bus_addr < `DATA_BASE + `TCM_SPAN &&
                         (bus_addr[14] ? cur.data_size == 2'h2
                                       : cur.data_size != 2'h0)) begin
                next_cur.bus_target = TGT_FAST;
                next_cur.bus_block  = bus_addr[14] ? `DATA_SECOND
                                                   : `DATA_FIRST;
            end else if (bus_addr >= `SRAM16_BASE &&
                         bus_addr < `SRAM16_BASE + `BLOCK_BYTES) begin
                next_cur.bus_target = TGT_SRAM16;
            end else if (bus_addr >= `PERIPH_LO &&
                         bus_addr <= `PERIPH_HI) begin
                next_cur.bus_target = TGT_PERIPH;
                next_cur.periph_sel = 4'((bus_addr - `PERIPH_LO) >>
                                         `BLOCK_AW);
            end else begin
                next_cur.bus_error = 1'b1;
            end
        end
        // coupled ports, one cycle each
        // second half answers only in the 32K setting
        next_cur.instr_port_ready = instr_port_req &&
            (instr_port_addr[14] ? cur.instr_size == 2'h2
                                 : cur.instr_size != 2'h0);
        next_cur.instr_port_block = instr_port_addr[14] ? `INSTR_SECOND
                                                         : `INSTR_FIRST;
        next_cur.data_port_ready = data_port_req &&
            (data_port_addr[14] ? cur.data_size == 2'h2
                                : cur.data_size != 2'h0);
        next_cur.data_port_block = data_port_addr[14] ? `DATA_SECOND
                                                       : `DATA_FIRST;
    end

    // register the state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign bus_ready  = cur.bus_ready;
    assign bus_error  = cur.bus_error;
    assign bus_target = cur.bus_target;
    assign bus_block  = cur.bus_block;
    assign bus_offset = cur.bus_offset;
    assign periph_sel = cur.periph_sel;
    assign instr_port_ready = cur.instr_port_ready;
    assign instr_port_block = cur.instr_port_block;
    assign data_port_ready  = cur.data_port_ready;
    assign data_port_block  = cur.data_port_block;
    assign instr_size = cur.instr_size;
    assign data_size  = cur.data_size;
    assign boot_sel   = cur.boot_sel;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    a_bus_single: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        bus_req |=> bus_ready) else $error("bus access not done");
    a_top_block: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        bus_req && in_sys && bus_addr[16:14] == 3'h0 && !remap
        |=> bus_block == 3'h4) else $error("slot0 not block 4");
    a_instr_first: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        instr_port_req && !instr_port_addr[14] |=> instr_port_block == 3'h1)
        else $error("instr block wrong");
    a_instr_second: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        bus_req && bus_addr[31:14] == 18'h00041 && instr_size == 2'h2
        |=> bus_target == 3'h1 && bus_block == 3'h0)
        else $error("instr second half wrong");
    a_data_first: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        data_port_req && !data_port_addr[14] |=> data_port_block == 3'h3)
        else $error("data block wrong");
    a_size_hold: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        bus_req |=> $stable(instr_size) && $stable(data_size))
        else $error("size moved");
    a_sram16_hit: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        bus_req && bus_addr[31:14] == 18'h00140 |=> bus_target == 3'h2)
        else $error("sram16 miss");
    a_periph_hit: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        bus_req && bus_addr == 32'hfffa_0000 |=> bus_target == 3'h5)
        else $error("periph miss");
    a_size_legal: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        instr_size != 2'h3 && data_size != 2'h3)
        else $error("size illegal");
    c_remap: cover property (@(posedge core_clk) bus_req && remap);
    c_full_tcm: cover property (@(posedge core_clk)
        instr_size == 2'h2 && data_size == 2'h2);
    c_periph: cover property (@(posedge core_clk) bus_target == 3'h5);
endmodule : sram_bank_alloc
`default_nettype wire

// [sram_bank_alloc_tb.sv]
// self-checking bench for the fast sram bank allocator
`timescale 1ns/1ps
`default_nettype none
`include "sram_alloc_cfg.svh"
module sram_bank_alloc_tb
    import sram_alloc_pkg::*;
;
    // ----------------------------------------
    // stimulus and checking
    // ----------------------------------------
    logic        core_clk, rst_n, remap, boot_source_select, bus_req;
    logic        bus_ready, bus_error, instr_port_req, instr_port_ready;
    logic        data_port_req, data_port_ready, boot_sel;
    logic [1:0]  instr_size_cfg, data_size_cfg, instr_size, data_size;
    logic [31:0] bus_addr;
    logic [14:0] instr_port_addr, data_port_addr;
    logic [2:0]  bus_target, bus_block, instr_port_block, data_port_block;
    logic [13:0] bus_offset;
    logic [3:0]  periph_sel;
    int          fail_count, checks_done;
    sram_bank_alloc DUT (.core_clk, .rst_n, .instr_size_cfg, .data_size_cfg,
        .remap, .boot_source_select, .bus_req, .bus_addr, .instr_port_req,
        .instr_port_addr, .data_port_req, .data_port_addr, .bus_ready,
        .bus_error, .bus_target, .bus_block, .bus_offset, .periph_sel,
        .instr_port_ready, .instr_port_block, .data_port_ready,
        .data_port_block, .instr_size, .data_size, .boot_sel);
    bus_master_model m (.core_clk, .bus_ready, .bus_error, .bus_target,
        .bus_block, .bus_offset, .periph_sel, .bus_req, .bus_addr);
    // free-running master clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic give_verdict();
        if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // one bus access judged on timing, target, block, offset, slot
    task automatic bus(input logic [31:0] a, input logic [2:0] t,
                       input logic [3:0] b);
        logic [2:0] tgt, blk;
        logic [13:0] off;
        logic [3:0] sel;
        logic err;
        int n;
        m.access(a, tgt, blk, off, sel, err, n);
        check(n, 1);
        if (n > 3) give_verdict();
        check(err, t == TGT_NONE);
        check(tgt, t);
        if (t == TGT_FAST) check(blk, b);
        if (t == TGT_FAST || t == TGT_SRAM16) check(off, a[13:0]);
        if (t == TGT_PERIPH) check(sel, b);
    endtask : bus
    // coupled port access, held through the edge that answers it
    task automatic tcm(input logic dp, input logic [14:0] a,
                       input logic r, input logic [2:0] b);
        @(posedge core_clk);
        #1 instr_port_req = !dp;
        data_port_req = dp;
        instr_port_addr = a;
        data_port_addr = a;
        @(posedge core_clk);
        #1 check(dp ? data_port_ready : instr_port_ready, r);
        if (r) check(dp ? data_port_block : instr_port_block, b);
        @(posedge core_clk);
        #1 instr_port_req = 1'b0;
        data_port_req = 1'b0;
        instr_port_addr = ~a;
        data_port_addr = ~a;
    endtask : tcm
    // k-th system slot: block 4, then unclaimed blocks descending
    function automatic logic [3:0] sys_blk(input int i, d, k);
        int seen;
        seen = 0;
        for (int b = 4; b >= 0; b--) begin
            if ((i > 0 && b == 1) || (i > 1 && b == 0)) continue;
            if ((d > 0 && b == 3) || (d > 1 && b == 2)) continue;
            if (seen == k) return 4'(b);
            seen++;
        end
        return 4'hf;
    endfunction : sys_blk
    // every size pair: sizes, system slots, coupled areas
    task automatic cfg_sweep();
        logic [3:0] e;
        for (int i = 0; i < 3; i++) for (int d = 0; d < 3; d++) begin
            @(posedge core_clk);
            #1 instr_size_cfg = 2'(i);
            data_size_cfg = 2'(d);
            repeat (3) @(posedge core_clk);
            #1 check(instr_size, i);
            check(data_size, d);
            for (int k = 0; k < 6; k++) begin
                e = sys_blk(i, d, k);
                bus(`SYS_BASE + k * `BLOCK_BYTES + 32'h0000_1234,
                    e == 4'hf ? TGT_NONE : TGT_FAST, e);
            end
            bus(`INSTR_BASE + 32'h10, i > 0 ? TGT_FAST : TGT_NONE, 1);
            bus(`INSTR_BASE + 32'h4010, i > 1 ? TGT_FAST : TGT_NONE, 0);
            bus(`DATA_BASE + 32'h20, d > 0 ? TGT_FAST : TGT_NONE, 3);
            bus(`DATA_BASE + 32'h4020, d > 1 ? TGT_FAST : TGT_NONE, 2);
            tcm(1'b0, 15'h0008, i > 0, 3'h1);
            tcm(1'b0, 15'h4008, i > 1, 3'h0);
            tcm(1'b1, 15'h0008, d > 0, 3'h3);
            tcm(1'b1, 15'h4008, d > 1, 3'h2);
        end
    endtask : cfg_sweep
    // small sram and peripheral window edges
    task automatic window_edges();
        bus(`SRAM16_BASE + 32'h0abc, TGT_SRAM16, 0);
        bus(`SRAM16_BASE + `BLOCK_BYTES, TGT_NONE, 0);
        bus(`PERIPH_LO, TGT_PERIPH, 4'h0);
        bus(`PERIPH_LO + 32'h0000_7ffc, TGT_PERIPH, 4'h1);
        bus(`PERIPH_HI, TGT_PERIPH, 4'hb);
        bus(`PERIPH_LO - 32'h1, TGT_NONE, 0);
        bus(`PERIPH_HI + 32'h1, TGT_NONE, 0);
    endtask : window_edges
    // boot strap caught at reset, then remap onto the system area
    task automatic boot_remap(input logic bs);
        @(posedge core_clk);
        #1 rst_n = 1'b0;
        boot_source_select = bs;
        instr_size_cfg = 2'h0;
        data_size_cfg = 2'h0;
        repeat (2) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (6) @(posedge core_clk);
        #1 check(boot_sel, bs);
        bus(32'h0000_0100, bs ? TGT_ROM : TGT_EXT0, 0);
        remap = 1'b1;
        bus(32'h0000_0100, TGT_FAST, 4);
        bus(32'h0000_4100, TGT_FAST, 3);
        remap = 1'b0;
    endtask : boot_remap
    // size change under back-to-back requests waits for a gap
    task automatic size_hold();
        @(posedge core_clk);
        #1 m.bus_req = 1'b1;
        m.bus_addr = `SYS_BASE;
        instr_size_cfg = 2'h2;
        repeat (4) @(posedge core_clk);
        #1 check(instr_size, 2'h0);
        m.bus_req = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 check(instr_size, 2'h2);
    endtask : size_hold
    // reset, then each scenario in turn
    initial begin
        {rst_n, remap, boot_source_select} = 3'h1;
        {instr_port_req, data_port_req} = 2'h0;
        {instr_size_cfg, data_size_cfg} = 4'ha;
        {instr_port_addr, data_port_addr} = 30'h0;
        fail_count = 0;
        checks_done = 0;
        repeat (6) @(posedge core_clk);
        #1 check(instr_size, 2'h0);
        check(data_size, 2'h0);
        rst_n = 1'b1;
        cfg_sweep();
        window_edges();
        boot_remap(1'b1);
        boot_remap(1'b0);
        size_hold();
        give_verdict();
    end
endmodule : sram_bank_alloc_tb
`default_nettype wire
